// ==== lic_consts.svh ====
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// register instruction addresses
`define LIC_ADDR_BASE       32'h0000_001B
`define LIC_ADDR_RANGE_LO   32'h0000_0800
`define LIC_ADDR_RANGE_HI   32'h0000_0BFF
`define LIC_ADDR_IDENT      32'h0000_0802
`define LIC_ADDR_REVISION   32'h0000_0803
`define LIC_ADDR_TASK_PRI   32'h0000_0808
`define LIC_ADDR_PROC_PRI   32'h0000_080A
`define LIC_ADDR_DEST_FMT   32'h0000_080E
`define LIC_ADDR_ICMD       32'h0000_0830
`define LIC_ADDR_ICMD_HI    32'h0000_0831
`define LIC_ADDR_SELF       32'h0000_083F

// base control fields and reset value
`define LIC_BASE_EN_BIT     11
`define LIC_BASE_EXT_BIT    10
`define LIC_BASE_RST        64'h0000_0000_0000_0800

// message data word fields
`define LIC_MSG_VEC_MSB     7
`define LIC_MSG_VEC_LSB     0
`define LIC_MSG_MODE_MSB    10
`define LIC_MSG_MODE_LSB    8
`define LIC_MSG_LVL_BIT     14
`define LIC_MSG_TRIG_BIT    15
`define LIC_VEC_MIN         8'h10
`define LIC_VEC_MAX         8'hFE

// delivery mode codes
`define LIC_DM_FIXED        3'h0
`define LIC_DM_LOWEST       3'h1
`define LIC_DM_SYS_MGMT     3'h2
`define LIC_DM_NMI          3'h4
`define LIC_DM_INIT         3'h5
`define LIC_DM_LEGACY_EXT   3'h7

// controller register map on the bus (byte offsets)
`define LIC_R_CMD           8'h00
`define LIC_R_ADDR          8'h04
`define LIC_R_LO            8'h08
`define LIC_R_HI            8'h0C
`define LIC_R_STATUS        8'h10
`define LIC_R_RES_LO        8'h14
`define LIC_R_RES_HI        8'h18
`define LIC_R_MSG           8'h1C

// controller field positions
`define LIC_CMD_GO_BIT      0
`define LIC_CMD_WR_BIT      1
`define LIC_ST_BUSY_BIT     0
`define LIC_ST_DONE_BIT     1
`define LIC_ST_FAULT_BIT    2
`define LIC_ST_REFUSED_BIT  3

`endif

// ==== lic_pkg.sv ====
package lic_pkg;

  typedef enum logic {
    LIC_HS_IDLE,
    LIC_HS_WAIT
  } lic_hst_e;

  typedef struct packed {
    logic [63:0] base;
    logic [7:0]  task_priority;
    logic [63:0] icmd;
    logic        rsp_valid;
    logic        rsp_fault;
    logic [31:0] rsp_lo;
    logic [31:0] rsp_hi;
    logic        ipi_valid;
    logic        self_valid;
    logic [7:0]  self_vec;
    logic        dlv_valid;
    logic [2:0]  dlv_mode;
    logic [7:0]  dlv_vector;
    logic        dlv_level;
    logic        dlv_assert;
    logic        dlv_lowest;
    logic        dlv_legacy;
  } lic_dev_s;

  typedef struct packed {
    lic_hst_e    state;
    logic        dp;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic        rd_rdy;
    logic [31:0] rdata;
    logic [31:0] addr;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    logic        done;
    logic        fault;
    logic        refused;
    logic [31:0] msg;
    logic        req_valid;
    logic        req_write;
    logic        msg_valid;
    logic [31:0] msg_out;
  } lic_host_s;

endpackage

// ==== lic_if.sv ====
`timescale 1ns/1ps
interface lic_if;
  logic        req_valid;
  logic        req_write;
  logic [31:0] req_addr;
  logic [31:0] req_lo;
  logic [31:0] req_hi;
  logic        rsp_valid;
  logic        rsp_fault;
  logic [31:0] rsp_lo;
  logic [31:0] rsp_hi;
  logic        msg_valid;
  logic [31:0] msg_data;

  modport dev (
    input  req_valid, req_write, req_addr, req_lo, req_hi, msg_valid, msg_data,
    output rsp_valid, rsp_fault, rsp_lo, rsp_hi
  );
  modport host (
    output req_valid, req_write, req_addr, req_lo, req_hi, msg_valid, msg_data,
    input  rsp_valid, rsp_fault, rsp_lo, rsp_hi
  );
endinterface // lic_if

// ==== lic_device.sv ====
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "lic_consts.svh"

// Behaviour
// RULE1 - sender keeps vectors within 010H to 0FEH
// RULE2 - fixed mode delivers to all, edge or level
// RULE3 - lowest priority mode targets lowest-priority agent
// RULE4 - system management mode edge only, vector zero
// RULE5 - non-maskable mode always edge, vector ignored
// RULE6 - initialization mode always edge, vector ignored
// RULE7 - legacy external mode drives legacy request edge
// RULE8 - level bit used only for level messages
// RULE9 - trigger bit zero edge, one level
// RULE10 - reserved message bits written back unchanged
// RULE11 - base control bit 10 enables extended mode
// RULE12 - enable pair decodes disabled, invalid, legacy, extended
// RULE13 - extended to legacy write faults
// RULE14 - leave extended only by clearing both bits
// RULE15 - read returns low word, high word
// RULE16 - write high word only for command register
// RULE17 - 800H to BFFH dedicated in extended mode
// RULE18 - destination format address 80EH unimplemented
// RULE19 - command register is one 64-bit at 830H
// RULE20 - self interrupt exists only at 83FH
// RULE21 - unlisted dedicated addresses raise a fault
// RULE22 - one address per legacy register, upper reserved
module lic_device #(
  parameter logic        EXT_SUPPORT = 1'b1,
  parameter logic [31:0] IDENT_VAL   = 32'h0000_0000,  // arbitrary
  parameter logic [31:0] REVISION    = 32'h0001_0014   // arbitrary
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  lic_if.dev               bus,
  output logic             ctl_enabled,
  output logic             ctl_extended,
  output logic             ext_supported,
  output logic             ipi_valid,
  output logic [63:0]      ipi_cmd,
  output logic             self_valid,
  output logic [7:0]       self_vector,
  output logic             dlv_valid,
  output logic [2:0]       dlv_mode,
  output logic [7:0]       dlv_vector,
  output logic             dlv_level_sens,
  output logic             dlv_assert,
  output logic             dlv_lowest,
  output logic             dlv_legacy_req
);
  import lic_pkg::*;

  lic_dev_s    s_r;
  lic_dev_s    s_nxt;
  logic        ext;
  logic        flt;
  logic [63:0] rd;
  logic        wr_en;
  logic        wr_ext;
  logic [2:0]  mmode;
  logic        level_msg;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt            = s_r;
    s_nxt.rsp_valid  = 1'b0;
    s_nxt.rsp_fault  = 1'b0;
    s_nxt.ipi_valid  = 1'b0;
    s_nxt.self_valid = 1'b0;
    s_nxt.dlv_valid  = 1'b0;
    s_nxt.dlv_lowest = 1'b0;
    s_nxt.dlv_legacy = 1'b0;
    ext       = s_r.base[`LIC_BASE_EN_BIT] & s_r.base[`LIC_BASE_EXT_BIT];  // see RULE12
    flt       = 1'b0;
    rd        = 64'h0000_0000_0000_0000;
    wr_en     = bus.req_lo[`LIC_BASE_EN_BIT];
    wr_ext    = bus.req_lo[`LIC_BASE_EXT_BIT];
    mmode     = bus.msg_data[`LIC_MSG_MODE_MSB:`LIC_MSG_MODE_LSB];
    level_msg = bus.msg_data[`LIC_MSG_TRIG_BIT];

    // register instructions
    if (bus.req_valid) begin
      s_nxt.rsp_valid = 1'b1;
      if (bus.req_addr == `LIC_ADDR_BASE) begin
        rd = s_r.base;
        if (bus.req_write) begin
          // a refused base write leaves the mode as it was
          if (wr_ext && !wr_en) begin
            flt = 1'b1;                                       // see RULE12
          end else if (wr_ext && !EXT_SUPPORT) begin
            flt = 1'b1;                                       // see RULE11
          end else if (ext && wr_en && !wr_ext) begin
            flt = 1'b1;                                       // see RULE13 see RULE14
          end else begin
            s_nxt.base = {bus.req_hi, bus.req_lo};            // see RULE11
          end
        end
      end else if (bus.req_addr >= `LIC_ADDR_RANGE_LO && bus.req_addr <= `LIC_ADDR_RANGE_HI) begin
        if (!ext) begin
          flt = 1'b1;                                         // see RULE17
        end else begin
          // upper word reads as zero for all 32-bit registers
          case (bus.req_addr)                                 // see RULE22
            `LIC_ADDR_IDENT: begin
              rd  = {32'h0000_0000, IDENT_VAL};
              flt = bus.req_write;
            end
            `LIC_ADDR_REVISION: begin
              rd  = {32'h0000_0000, REVISION};
              flt = bus.req_write;
            end
            `LIC_ADDR_TASK_PRI: begin
              rd = {56'h0000_0000_0000_00, s_r.task_priority};
              if (bus.req_write) begin
                s_nxt.task_priority = bus.req_lo[7:0];                  // see RULE16
              end
            end
            `LIC_ADDR_PROC_PRI: begin
              rd  = {56'h0000_0000_0000_00, s_r.task_priority};
              flt = bus.req_write;
            end
            `LIC_ADDR_ICMD: begin
              rd = s_r.icmd;                                  // see RULE19
              if (bus.req_write) begin
                s_nxt.icmd      = {bus.req_hi, bus.req_lo};   // see RULE16
                s_nxt.ipi_valid = 1'b1;
              end
            end
            `LIC_ADDR_SELF: begin
              flt = !bus.req_write;                           // see RULE20
              if (bus.req_write) begin
                s_nxt.self_valid = 1'b1;
                s_nxt.self_vec   = bus.req_lo[7:0];
              end
            end
            default: flt = 1'b1;                              // see RULE18 see RULE21
          endcase
        end
      end else begin
        flt = 1'b1;
      end
      // a faulted answer carries no data and changes no state
      s_nxt.rsp_fault = flt;
      s_nxt.rsp_lo    = flt ? 32'h0000_0000 : rd[31:0];       // see RULE15
      s_nxt.rsp_hi    = flt ? 32'h0000_0000 : rd[63:32];      // see RULE15
    end

    // message decode, accepted only while globally enabled
    if (bus.msg_valid && s_r.base[`LIC_BASE_EN_BIT]) begin
      s_nxt.dlv_mode   = mmode;
      s_nxt.dlv_vector = 8'h00;
      s_nxt.dlv_level  = 1'b0;
      s_nxt.dlv_assert = 1'b1;                                // see RULE8
      case (mmode)
        `LIC_DM_FIXED, `LIC_DM_LOWEST: begin                  // see RULE2 see RULE3
          s_nxt.dlv_valid  = 1'b1;
          s_nxt.dlv_vector = bus.msg_data[`LIC_MSG_VEC_MSB:`LIC_MSG_VEC_LSB];
          s_nxt.dlv_level  = level_msg;                       // see RULE9
          s_nxt.dlv_assert = level_msg ? bus.msg_data[`LIC_MSG_LVL_BIT] : 1'b1;  // see RULE8
          s_nxt.dlv_lowest = mmode == `LIC_DM_LOWEST;         // see RULE3
        end
        // vector and trigger bit ignored, delivery is edge
        `LIC_DM_SYS_MGMT, `LIC_DM_NMI, `LIC_DM_INIT: begin
          s_nxt.dlv_valid = 1'b1;                             // see RULE4 see RULE5 see RULE6
        end
        // vector comes later from the acknowledge cycle
        `LIC_DM_LEGACY_EXT: begin
          s_nxt.dlv_valid  = 1'b1;
          s_nxt.dlv_legacy = 1'b1;                            // see RULE7
        end
        // modes 3 and 6 are reserved and dropped
        default: s_nxt.dlv_valid = 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      // out of reset: enabled, legacy mode
      s_r      <= '0;
      s_r.base <= `LIC_BASE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign bus.rsp_valid  = s_r.rsp_valid;
  assign bus.rsp_fault  = s_r.rsp_fault;
  assign bus.rsp_lo     = s_r.rsp_lo;
  assign bus.rsp_hi     = s_r.rsp_hi;
  assign ctl_enabled    = s_r.base[`LIC_BASE_EN_BIT];
  assign ctl_extended   = ext;
  assign ext_supported  = EXT_SUPPORT;                        // see RULE11
  assign ipi_valid      = s_r.ipi_valid;
  assign ipi_cmd        = s_r.icmd;
  assign self_valid     = s_r.self_valid;
  assign self_vector    = s_r.self_vec;
  assign dlv_valid      = s_r.dlv_valid;
  assign dlv_mode       = s_r.dlv_mode;
  assign dlv_vector     = s_r.dlv_vector;
  assign dlv_level_sens = s_r.dlv_level;
  assign dlv_assert     = s_r.dlv_assert;
  // kind flags are registered beside the decoded message
  assign dlv_lowest     = s_r.dlv_lowest;                     // see RULE3
  assign dlv_legacy_req = s_r.dlv_legacy;                     // see RULE7

endmodule // lic_device

// ==== lic_host.sv ====
`timescale 1ns/1ps
`include "lic_consts.svh"

module lic_host (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  lic_if.host              bus
);
  import lic_pkg::*;

  lic_host_s   s_r;
  lic_host_s   s_nxt;
  logic        rdy;
  logic [31:0] rmux;
  logic [2:0]  wmode;
  logic [7:0]  wvec;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt           = s_r;
    s_nxt.req_valid = 1'b0;
    s_nxt.msg_valid = 1'b0;
    rdy   = !(s_r.dp && !s_r.dp_wr && !s_r.rd_rdy);
    wmode = hwdata[`LIC_MSG_MODE_MSB:`LIC_MSG_MODE_LSB];
    wvec  = hwdata[`LIC_MSG_VEC_MSB:`LIC_MSG_VEC_LSB];
    rmux  = 32'h0000_0000;
    case (s_r.dp_addr)
      `LIC_R_ADDR:   rmux = s_r.addr;
      `LIC_R_LO:     rmux = s_r.lo;
      `LIC_R_HI:     rmux = s_r.hi;
      `LIC_R_STATUS: rmux = {28'h000_0000, s_r.refused, s_r.fault, s_r.done, s_r.state == LIC_HS_WAIT};
      `LIC_R_RES_LO: rmux = s_r.res_lo;
      `LIC_R_RES_HI: rmux = s_r.res_hi;
      `LIC_R_MSG:    rmux = s_r.msg;                // see RULE10
      default:       rmux = 32'h0000_0000;
    endcase

    // write data phase
    if (s_r.dp && s_r.dp_wr) begin
      case (s_r.dp_addr)
        `LIC_R_CMD: begin
          if (hwdata[`LIC_CMD_GO_BIT] && s_r.state == LIC_HS_IDLE) begin
            s_nxt.req_valid = 1'b1;
            s_nxt.req_write = hwdata[`LIC_CMD_WR_BIT];
            s_nxt.state     = LIC_HS_WAIT;
            s_nxt.done      = 1'b0;
            s_nxt.fault     = 1'b0;
          end
        end
        `LIC_R_ADDR: s_nxt.addr = hwdata;
        `LIC_R_LO:   s_nxt.lo   = hwdata;
        `LIC_R_HI:   s_nxt.hi   = hwdata;
        `LIC_R_MSG: begin
          s_nxt.msg = hwdata;                       // see RULE10
          if ((wmode == `LIC_DM_FIXED || wmode == `LIC_DM_LOWEST) &&
              (wvec < `LIC_VEC_MIN || wvec > `LIC_VEC_MAX)) begin
            s_nxt.refused = 1'b1;                   // see RULE1
          end else begin
            s_nxt.refused   = 1'b0;
            s_nxt.msg_valid = 1'b1;
            s_nxt.msg_out   = hwdata;
            if (wmode == `LIC_DM_SYS_MGMT) begin
              s_nxt.msg_out[`LIC_MSG_VEC_MSB:`LIC_MSG_VEC_LSB] = 8'h00;  // see RULE4
            end
            if (!hwdata[`LIC_MSG_TRIG_BIT]) begin
              s_nxt.msg_out[`LIC_MSG_LVL_BIT] = 1'b1;                    // see RULE8
            end
          end
        end
        default: s_nxt.refused = s_r.refused;
      endcase
    end

    // read data phase takes one wait state
    if (s_r.dp && !s_r.dp_wr && !s_r.rd_rdy) begin
      s_nxt.rdata  = rmux;
      s_nxt.rd_rdy = 1'b1;
    end

    // address phase
    if (rdy) begin
      s_nxt.dp      = hsel && htrans[1] && hready;
      s_nxt.dp_wr   = hwrite;
      s_nxt.dp_addr = haddr[7:0];
      s_nxt.rd_rdy  = 1'b0;
    end

    // answer of the register instruction
    if (s_r.state == LIC_HS_WAIT && bus.rsp_valid) begin
      s_nxt.state  = LIC_HS_IDLE;
      s_nxt.done   = 1'b1;
      s_nxt.fault  = bus.rsp_fault;
      s_nxt.res_lo = bus.rsp_lo;
      s_nxt.res_hi = bus.rsp_hi;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign hreadyout     = rdy;
  assign hrdata        = s_r.rdata;
  assign hresp         = 1'b0;
  assign bus.req_valid = s_r.req_valid;
  assign bus.req_write = s_r.req_write;
  assign bus.req_addr  = s_r.addr;
  assign bus.req_lo    = s_r.lo;
  assign bus.req_hi    = s_r.hi;
  assign bus.msg_valid = s_r.msg_valid;
  assign bus.msg_data  = s_r.msg_out;

endmodule // lic_host

// ==== lic_chk.sv ====
`timescale 1ns/1ps
`include "lic_consts.svh"
module lic_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_lo,
  input wire logic        rsp_valid,
  input wire logic        rsp_fault,
  input wire logic [31:0] rsp_lo,
  input wire logic [31:0] rsp_hi,
  input wire logic        msg_valid,
  input wire logic [31:0] msg_data
);
  logic       ext_r;
  logic [2:0] md;
  logic       bw_r;
  logic [1:0] bm_r;
  logic       bw;

  assign bw = req_valid && req_write && req_addr == `LIC_ADDR_BASE;
  assign md = msg_data[`LIC_MSG_MODE_MSB:`LIC_MSG_MODE_LSB];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // extended mode as seen from answered base control writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_r <= 1'b0;
      bw_r  <= 1'b0;
      bm_r  <= 2'h0;
    end else begin
      if (req_valid) begin
        bw_r <= bw;
        bm_r <= req_lo[11:10];
      end
      if (rsp_valid && !rsp_fault && bw_r) begin
        ext_r <= &bm_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_rsp_one_later: assert property (rsp_valid == $past(req_valid))
    else $error("answer not one cycle after request");
  a_fault_no_data: assert property (rsp_valid && rsp_fault |-> rsp_lo == 32'h0 && rsp_hi == 32'h0)
    else $error("fault answer carries data");
  a_invalid_pair: assert property (bw && req_lo[11:10] == 2'b01 |=> rsp_fault)
    else $error("invalid enable pair accepted");
  a_no_ext_to_leg: assert property (bw && req_lo[11:10] == 2'b10 && ext_r |=> rsp_fault)
    else $error("extended to legacy write accepted");
  a_ext_exit_ok: assert property (bw && req_lo[11:10] == 2'b00 && ext_r |=> !rsp_fault)
    else $error("exit from extended mode refused");
  a_range_needs_ext: assert property (req_valid && !ext_r &&
    req_addr inside {[`LIC_ADDR_RANGE_LO:`LIC_ADDR_RANGE_HI]} |=> rsp_fault)
    else $error("dedicated range reachable outside extended mode");
  a_gap_addr_fault: assert property (req_valid &&
    req_addr inside {`LIC_ADDR_DEST_FMT, `LIC_ADDR_ICMD_HI} |=> rsp_fault)
    else $error("unimplemented address answered");
  a_self_no_read: assert property (req_valid && !req_write && req_addr == `LIC_ADDR_SELF |=> rsp_fault)
    else $error("self interrupt register readable");
  a_narrow_hi_zero: assert property (req_valid && !req_write && req_addr inside
    {`LIC_ADDR_IDENT, `LIC_ADDR_REVISION, `LIC_ADDR_TASK_PRI, `LIC_ADDR_PROC_PRI} |=> rsp_hi == 32'h0)
    else $error("narrow register returns high word");

  a_msg_vec_range: assert property (msg_valid && md inside {`LIC_DM_FIXED, `LIC_DM_LOWEST} |->
    msg_data[7:0] >= `LIC_VEC_MIN && msg_data[7:0] <= `LIC_VEC_MAX)
    else $error("message sent with vector out of range");
  a_sysmgmt_vec_zero: assert property (msg_valid && md == `LIC_DM_SYS_MGMT |-> msg_data[7:0] == 8'h00)
    else $error("system management message with nonzero vector");
  a_edge_msg_assert: assert property (msg_valid && !msg_data[`LIC_MSG_TRIG_BIT] |->
    msg_data[`LIC_MSG_LVL_BIT])
    else $error("edge message sent as deassert");

  c_fault: cover property (rsp_valid && rsp_fault);
  c_msg_sent: cover property (msg_valid);
  c_ext_ok: cover property (rsp_valid && !rsp_fault && ext_r);
  c_icmd_wr: cover property (req_valid && req_write && req_addr == `LIC_ADDR_ICMD);
endmodule // lic_chk

// ==== tb_local_irq_msg_decode_ext_mode.sv ====
`timescale 1ns/1ps
`include "lic_consts.svh"
module tb_local_irq_msg_decode_ext_mode;
  import lic_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        ctl_enabled, ctl_extended, ext_supported, ipi_valid, self_valid;
  logic [63:0] ipi_cmd;
  logic [7:0]  self_vector, dlv_vector;
  logic        dlv_valid, dlv_level_sens, dlv_assert, dlv_lowest, dlv_legacy_req;
  logic [2:0]  dlv_mode;
  logic [14:0] dlv_got;
  logic [31:0] rnd = 32'h4015;
  int          dlv_cnt, ipi_cnt, self_cnt, error_cnt, n_checks;

  lic_if i_lic_if ();
  lic_host i_lic_host (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
    .bus(i_lic_if));
  lic_device i_lic_device (.mclk(mclk), .rst(rst), .bus(i_lic_if), .ctl_enabled(ctl_enabled),
    .ctl_extended(ctl_extended), .ext_supported(ext_supported), .ipi_valid(ipi_valid), .ipi_cmd(ipi_cmd),
    .self_valid(self_valid), .self_vector(self_vector), .dlv_valid(dlv_valid), .dlv_mode(dlv_mode),
    .dlv_vector(dlv_vector), .dlv_level_sens(dlv_level_sens), .dlv_assert(dlv_assert),
    .dlv_lowest(dlv_lowest), .dlv_legacy_req(dlv_legacy_req));
  lic_chk i_lic_chk (.mclk(mclk), .rst(rst), .req_valid(i_lic_if.req_valid), .req_write(i_lic_if.req_write),
    .req_addr(i_lic_if.req_addr), .req_lo(i_lic_if.req_lo), .rsp_valid(i_lic_if.rsp_valid),
    .rsp_fault(i_lic_if.rsp_fault), .rsp_lo(i_lic_if.rsp_lo), .rsp_hi(i_lic_if.rsp_hi),
    .msg_valid(i_lic_if.msg_valid), .msg_data(i_lic_if.msg_data));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (ipi_valid === 1'b1) ipi_cnt++;
    if (self_valid === 1'b1) self_cnt++;
    if (dlv_valid === 1'b1) begin
      dlv_cnt++;
      dlv_got = {dlv_mode, dlv_vector, dlv_level_sens, dlv_assert, dlv_lowest, dlv_legacy_req};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // modes 2,4,5,7 drop the vector and are edge
  function automatic logic [14:0] exp_dlv(input logic [31:0] d);
    logic lv;
    lv = d[15] && !(d[10:8] inside {3'h2, 3'h4, 3'h5, 3'h7});
    return {d[10:8], (d[10] || d[9]) ? 8'h00 : d[7:0], lv, lv ? d[14] : 1'b1, d[10:8] == 3'h1, d[10:8] == 3'h7};
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic ev(input logic w, input logic [31:0] a, lo, hi, input logic ef, input logic [63:0] er);
    logic [31:0] q;
    logic [63:0] r;
    ahb(1'b1, `LIC_R_ADDR, a, q);
    ahb(1'b1, `LIC_R_LO, lo, q);
    ahb(1'b1, `LIC_R_HI, hi, q);
    ahb(1'b1, `LIC_R_CMD, {30'h0, w, 1'b1}, q);
    repeat (3) @(posedge mclk);
    do ahb(1'b0, `LIC_R_STATUS, 32'h0, q); while (q[1:0] !== 2'b10);
    chk("fault", ef, q[2]);
    ahb(1'b0, `LIC_R_RES_LO, 32'h0, r[31:0]);
    ahb(1'b0, `LIC_R_RES_HI, 32'h0, r[63:32]);
    if (!w && !ef) chk("result", er, r);
  endtask

  task automatic msg(input logic [31:0] d, input logic on);
    logic [31:0] q;
    logic        rf;
    int          c;
    c = dlv_cnt;
    rf = d[10:8] < 3'h2 && (d[7:0] < `LIC_VEC_MIN || d[7:0] > `LIC_VEC_MAX);
    on = on && !(d[10:8] inside {3'h3, 3'h6}) && !rf;
    ahb(1'b1, `LIC_R_MSG, d, q);
    repeat (4) @(posedge mclk);
    ahb(1'b0, `LIC_R_MSG, 32'h0, q);
    chk("msg_word", d, q);
    chk("dlv_count", on, dlv_cnt - c);
    if (on) chk("dlv", exp_dlv(d), dlv_got);
    ahb(1'b0, `LIC_R_STATUS, 32'h0, q);
    chk("refused", rf, q[3]);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    $display("MISMATCH watchdog expected done seen hang");
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, a, b;
    int          c;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    ahb(1'b0, `LIC_R_STATUS, 32'h0, q);
    chk("status", 32'h0, q);
    chk("ext_supported", 1'b1, ext_supported);
    ev(1'b0, `LIC_ADDR_BASE, 32'h0, 32'h0, 1'b0, 64'h800);
    ev(1'b0, `LIC_ADDR_TASK_PRI, 32'h0, 32'h0, 1'b1, 64'h0);
    ev(1'b1, `LIC_ADDR_BASE, 32'h0400, 32'h0, 1'b1, 64'h0);
    ev(1'b1, `LIC_ADDR_BASE, 32'h0c00, 32'h0, 1'b0, 64'h0);
    chk("extended", 1'b1, ctl_extended);
    ev(1'b1, `LIC_ADDR_BASE, 32'h0800, 32'h0, 1'b1, 64'h0);
    chk("still_ext", 1'b1, ctl_extended);
    $display("test mode_switch done");
    rnd = nxt(rnd);
    a = rnd;
    rnd = nxt(rnd);
    b = rnd;
    c = ipi_cnt;
    ev(1'b1, `LIC_ADDR_ICMD, a, b, 1'b0, 64'h0);
    chk("ipi_count", 1, ipi_cnt - c);
    chk("ipi_cmd", {b, a}, ipi_cmd);
    ev(1'b0, `LIC_ADDR_ICMD, 32'h0, 32'h0, 1'b0, {b, a});
    ev(1'b1, `LIC_ADDR_TASK_PRI, a, b, 1'b0, 64'h0);
    ev(1'b0, `LIC_ADDR_TASK_PRI, 32'h0, 32'h0, 1'b0, {56'h0, a[7:0]});
    ev(1'b0, `LIC_ADDR_PROC_PRI, 32'h0, 32'h0, 1'b0, {56'h0, a[7:0]});
    c = self_cnt;
    ev(1'b1, `LIC_ADDR_SELF, b, 32'h0, 1'b0, 64'h0);
    chk("self_count", 1, self_cnt - c);
    chk("self_vector", b[7:0], self_vector);
    for (int i = 0; i < 4; i++) begin
      ev(i[0], i[1] ? `LIC_ADDR_ICMD_HI : `LIC_ADDR_DEST_FMT, a, b, 1'b1, 64'h0);
    end
    ev(1'b0, `LIC_ADDR_SELF, 32'h0, 32'h0, 1'b1, 64'h0);
    ev(1'b1, `LIC_ADDR_IDENT, a, 32'h0, 1'b1, 64'h0);
    ev(1'b0, {24'h9, b[7:0]}, 32'h0, 32'h0, 1'b1, 64'h0);
    ev(1'b0, 32'h0c00, 32'h0, 32'h0, 1'b1, 64'h0);
    $display("test registers done");
    ev(1'b1, `LIC_ADDR_BASE, 32'h0, 32'h0, 1'b0, 64'h0);
    chk("disabled", 2'b00, {ctl_enabled, ctl_extended});
    msg(32'h0031, 1'b0);
    ev(1'b1, `LIC_ADDR_BASE, 32'h0800, 32'h0, 1'b0, 64'h0);
    chk("legacy", 2'b10, {ctl_enabled, ctl_extended});
    msg(32'h800f, 1'b1);
    msg(32'h01fe, 1'b1);
    msg(32'h80ff, 1'b1);
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        rnd = nxt(rnd);
        msg({rnd[31:16], k[1:0], rnd[13:11], m[2:0], rnd[7:0]}, 1'b1);
      end
    end
    $display("test messages done");
    finish_test();
  end
endmodule // tb_local_irq_msg_decode_ext_mode
